/* rtl/tsu_task_switch.sv */
// Purpose: Task switch sequencer with task selector register
// Assumes: Descriptors are fetched and presented by the core
// Notes: Memory port is a simple request/ack master
`timescale 1ns/10ps

// What this block does
// - Jump or call to a state segment or task gate runs a full switch.
// - Outgoing state, every slot but the back link, is written out before incoming state is read.
// - Selector register written by load instruction and by a completed switch, read out by store instruction and, as back link, by a call.
// - Selector access needs protected mode; loading needs privilege 0.
// - Loaded selector must index a state segment descriptor in the global table.
// - Only the 16-bit selector is readable; base, limit, rights stay hidden.
// - 32-bit and 16-bit segment formats, chosen by descriptor type.
// - Task gate needs requested and current privilege below gate privilege.
// - The privilege field inside the gate's own selector is ignored.
// - I/O map base field of a 32-bit segment points to the I/O bitmap.
// - 32-bit segment word order from back link to I/O map base.
// - 16-bit segment word order from back link to local table selector.
module tsu_task_switch
  import tsu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_prot_mode,
  input wire logic [1:0] i_cur_priv,
  input wire logic i_req_valid,
  input wire tsu_op_t i_req_op,
  input wire logic [15:0] i_req_sel,
  input wire logic [3:0] i_desc_type,
  input wire logic [1:0] i_desc_priv,
  input wire logic [31:0] i_desc_base,
  input wire logic [31:0] i_desc_limit,
  input wire logic [15:0] i_gate_sel,
  input wire logic [3:0] i_tgt_type,
  input wire logic [31:0] i_tgt_base,
  input wire logic [31:0] i_tgt_limit,
  input wire logic i_core_we,
  input wire logic [4:0] i_core_idx,
  input wire logic [31:0] i_core_wdata,
  output logic [31:0] o_core_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic o_mem_half,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic o_busy,
  output logic o_done,
  output logic o_fault,
  output logic [15:0] o_store_sel,
  output logic [15:0] o_iomap_base,
  output logic o_debug_trap
);
  tsu_state_t state_reg;
  logic [4:0] idx_reg;
  logic pend_reg;
  logic req_reg;
  logic we_reg;
  logic half_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic done_reg;
  logic fault_reg;
  logic [15:0] store_sel_reg;
  logic [15:0] iomap_reg;
  logic trap_reg;
  logic is_call_reg;

  // Task selector register; base, limit, type are internal only
  logic [15:0] task_sel_reg;
  logic [31:0] task_base_reg;
  logic [31:0] task_limit_reg;
  logic task_wide_reg;

  // Incoming task captured at request time
  logic [15:0] new_sel_reg;
  logic [31:0] new_base_reg;
  logic [31:0] new_limit_reg;
  logic new_wide_reg;

  logic gate_ok;
  logic load_ok;
  logic store_ok;
  logic is_gate;
  logic [3:0] eff_type;
  logic tgt_is_seg;
  logic accept;
  logic cur_wide;
  logic [31:0] cur_base;
  logic slot_ok;
  logic last_slot;

  tsu_ram_if ram ();

  tsu_state_ram #(
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .i_clk(i_clk),
    .port(ram.mem)
  );

  tsu_priv_check u_priv (
    .i_prot_mode(i_prot_mode),
    .i_cur_priv(i_cur_priv),
    .i_req_priv(i_req_sel[1:0]),
    .i_gate_priv(i_desc_priv),
    .i_is_gate(is_gate),
    .o_gate_ok(gate_ok),
    .o_load_ok(load_ok),
    .o_store_ok(store_ok)
  );

  // Selector slots of either layout
  function automatic logic is_sel_slot(input logic [4:0] idx);
    is_sel_slot = (idx == SLOT_LINK) || (idx == SLOT_SS0) || (idx == SLOT_SS1)
                  || (idx == SLOT_SS2) || ((idx >= SLOT_SEG_ES) && (idx <= SLOT_LOCAL));
  endfunction : is_sel_slot

  // Slot exists in the 16-bit layout
  function automatic logic slot16_ok(input logic [4:0] idx);
    slot16_ok = (idx < SLOT_PDBR) || ((idx > SLOT_PDBR) && (idx <= SLOT_SEG_DS))
                || (idx == SLOT_LOCAL);
  endfunction : slot16_ok

  // 16-bit word offset: skips page base, FS, GS
  function automatic logic [4:0] slot16_ofs(input logic [4:0] idx);
    if (idx < SLOT_PDBR) begin
      slot16_ofs = idx;
    end else if (idx == SLOT_LOCAL) begin
      slot16_ofs = OFS16_LOCAL;
    end else begin
      slot16_ofs = idx - 5'h01;
    end
  endfunction : slot16_ofs

  // Byte address of a slot in a segment of either format
  function automatic logic [31:0] slot_addr(input logic [31:0] base,
                                            input logic wide,
                                            input logic [4:0] idx);
    if (wide) begin
      slot_addr = base + (32'(idx) << SHIFT32);
    end else begin
      slot_addr = base + (32'(slot16_ofs(idx)) << SHIFT16);
    end
  endfunction : slot_addr

  // Upper half cleared for selectors and for 16-bit words
  function automatic logic [31:0] fit_word(input logic [31:0] d,
                                           input logic wide,
                                           input logic [4:0] idx);
    if (!wide || is_sel_slot(idx)) begin
      fit_word = {16'h0000, d[15:0]};
    end else begin
      fit_word = d;
    end
  endfunction : fit_word

  always_comb begin
    is_gate = (i_desc_type == TYPE_TASK_GATE);
    eff_type = is_gate ? i_tgt_type : i_desc_type;
    tgt_is_seg = (eff_type == TYPE_AVAIL16) || (eff_type == TYPE_AVAIL32);
    accept = i_req_valid && (state_reg == ST_IDLE);
    cur_wide = (state_reg == ST_SAVE) ? task_wide_reg : new_wide_reg;
    cur_base = (state_reg == ST_SAVE) ? task_base_reg : new_base_reg;
    slot_ok = cur_wide || slot16_ok(idx_reg);
    last_slot = (idx_reg == SLOT_LAST);
  end

  // State memory: core owns it while idle, sequencer while busy
  always_comb begin
    ram.raddr = (state_reg == ST_IDLE) ? i_core_idx : idx_reg;
    ram.we = 1'b0;
    ram.waddr = i_core_idx;
    ram.wdata = fit_word(i_core_wdata, 1'b1, i_core_idx);
    if (state_reg == ST_IDLE) begin
      ram.we = i_core_we;
    end else if ((state_reg == ST_LOAD) && req_reg && i_mem_ack) begin
      ram.we = 1'b1;
      ram.waddr = idx_reg;
      ram.wdata = fit_word(i_mem_rdata, new_wide_reg, idx_reg);
    end else if ((state_reg == ST_LINK) && req_reg && i_mem_ack) begin
      ram.we = 1'b1;
      ram.waddr = SLOT_LINK;
      ram.wdata = {16'h0000, task_sel_reg};
    end
  end

  // Sequencer and memory port
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      idx_reg <= SLOT_LINK;
      pend_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      half_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      is_call_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Switch only on jump or call to a segment or a gate to one
          if (accept && ((i_req_op == OP_JMP) || (i_req_op == OP_CALL))
              && tgt_is_seg && gate_ok) begin
            state_reg <= ST_SAVE;
            idx_reg <= SLOT_STK0;
            is_call_reg <= (i_req_op == OP_CALL);
          end
        end
        ST_SAVE, ST_LOAD: begin
          if (!slot_ok) begin
            idx_reg <= idx_reg + 5'h01;
          end else if (!req_reg && !pend_reg) begin
            pend_reg <= 1'b1;
          end else if (pend_reg) begin
            pend_reg <= 1'b0;
            req_reg <= 1'b1;
            we_reg <= (state_reg == ST_SAVE);
            half_reg <= !cur_wide;
            addr_reg <= slot_addr(cur_base, cur_wide, idx_reg);
            wdata_reg <= fit_word(ram.rdata, cur_wide, idx_reg);
          end else if (i_mem_ack) begin
            req_reg <= 1'b0;
            idx_reg <= idx_reg + 5'h01;
          end
          if (last_slot && (!slot_ok || (req_reg && i_mem_ack))) begin
            idx_reg <= SLOT_LINK;
            if (state_reg == ST_SAVE) begin
              state_reg <= ST_LOAD;
            end else begin
              state_reg <= is_call_reg ? ST_LINK : ST_DONE;
            end
          end
        end
        ST_LINK: begin
          // Call leaves the old selector as the new task's back link
          if (!req_reg) begin
            req_reg <= 1'b1;
            we_reg <= 1'b1;
            half_reg <= !new_wide_reg;
            addr_reg <= slot_addr(new_base_reg, new_wide_reg, SLOT_LINK);
            wdata_reg <= {16'h0000, task_sel_reg};
          end else if (i_mem_ack) begin
            req_reg <= 1'b0;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Incoming task capture; gate selector replaces the request selector
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      new_sel_reg <= SEL_RESET;
      new_base_reg <= 32'h0000_0000;
      new_limit_reg <= 32'h0000_0000;
      new_wide_reg <= 1'b0;
    end else if (accept) begin
      new_sel_reg <= is_gate ? i_gate_sel : i_req_sel;
      new_base_reg <= is_gate ? i_tgt_base : i_desc_base;
      new_limit_reg <= is_gate ? i_tgt_limit : i_desc_limit;
      new_wide_reg <= eff_type[TYPE_WIDE_BIT];
    end
  end

  // Task selector register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      task_sel_reg <= SEL_RESET;
      task_base_reg <= 32'h0000_0000;
      task_limit_reg <= 32'h0000_0000;
      task_wide_reg <= 1'b0;
    end else if (accept && (i_req_op == OP_LOAD_SEL) && load_ok
                 && !i_req_sel[SEL_TI_BIT] && tgt_is_seg && !is_gate) begin
      task_sel_reg <= i_req_sel;
      task_base_reg <= i_desc_base;
      task_limit_reg <= i_desc_limit;
      task_wide_reg <= i_desc_type[TYPE_WIDE_BIT];
    end else if (state_reg == ST_DONE) begin
      task_sel_reg <= new_sel_reg;
      task_base_reg <= new_base_reg;
      task_limit_reg <= new_limit_reg;
      task_wide_reg <= new_wide_reg;
    end
  end

  // Store instruction result, the only readable view of the register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      store_sel_reg <= SEL_RESET;
    end else if (accept && (i_req_op == OP_STORE_SEL) && store_ok) begin
      store_sel_reg <= task_sel_reg;
    end
  end

  // I/O bitmap pointer and debug trap from a loaded 32-bit segment
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      iomap_reg <= IOMAP_TYPICAL;
      trap_reg <= 1'b0;
    end else if ((state_reg == ST_LOAD) && req_reg && i_mem_ack
                 && (idx_reg == SLOT_IOMAP) && new_wide_reg) begin
      iomap_reg <= i_mem_rdata[IOMAP_LSB +: 16];
      trap_reg <= i_mem_rdata[TRAP_BIT];
    end
  end

  // Completion and fault pulses
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      if (state_reg == ST_DONE) begin
        done_reg <= 1'b1;
      end else if (accept) begin
        case (i_req_op)
          OP_JMP, OP_CALL: begin
            if (tgt_is_seg && gate_ok) begin
              done_reg <= 1'b0;
            end else begin
              fault_reg <= 1'b1;
            end
          end
          OP_LOAD_SEL: begin
            if (load_ok && !i_req_sel[SEL_TI_BIT] && tgt_is_seg && !is_gate) begin
              done_reg <= 1'b1;
            end else begin
              fault_reg <= 1'b1;
            end
          end
          OP_STORE_SEL: begin
            done_reg <= store_ok;
            fault_reg <= !store_ok;
          end
          default: begin
            fault_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  always_comb begin
    o_core_rdata = ram.rdata;
    o_mem_req = req_reg;
    o_mem_we = we_reg;
    o_mem_half = half_reg;
    o_mem_addr = addr_reg;
    o_mem_wdata = wdata_reg;
    o_busy = (state_reg != ST_IDLE);
    o_done = done_reg;
    o_fault = fault_reg;
    o_store_sel = store_sel_reg;
    o_iomap_base = iomap_reg;
    o_debug_trap = trap_reg;
  end
endmodule : tsu_task_switch

/* rtl/tsu_pkg.sv */
// Purpose: Shared constants and types for the task switch unit
// Assumes: Word slots follow the 32-bit state segment order
// Notes: 16-bit layout is derived from the 32-bit slot index
package tsu_pkg;
  localparam int SLOT_W = 5;
  localparam int DATA_W = 32;
  localparam int SEL_W = 16;
  localparam int RAM_DEPTH = 32;

  // Slot indices of the 32-bit state segment, one per 32-bit word
  localparam logic [4:0] SLOT_LINK = 5'h00;
  localparam logic [4:0] SLOT_STK0 = 5'h01;
  localparam logic [4:0] SLOT_SS0 = 5'h02;
  localparam logic [4:0] SLOT_SS1 = 5'h04;
  localparam logic [4:0] SLOT_SS2 = 5'h06;
  localparam logic [4:0] SLOT_PDBR = 5'h07;
  localparam logic [4:0] SLOT_SEG_ES = 5'h12;
  localparam logic [4:0] SLOT_SEG_DS = 5'h15;
  localparam logic [4:0] SLOT_SEG_GS = 5'h17;
  localparam logic [4:0] SLOT_LOCAL = 5'h18;
  localparam logic [4:0] SLOT_IOMAP = 5'h19;
  localparam logic [4:0] SLOT_LAST = 5'h19;
  localparam logic [4:0] OFS16_LOCAL = 5'h15;

  // Byte address scaling per format
  localparam int SHIFT32 = 2;
  localparam int SHIFT16 = 1;

  // Descriptor type codes
  localparam logic [3:0] TYPE_AVAIL16 = 4'h1;
  localparam logic [3:0] TYPE_TASK_GATE = 4'h5;
  localparam logic [3:0] TYPE_AVAIL32 = 4'h9;
  localparam int TYPE_WIDE_BIT = 3;

  localparam int SEL_TI_BIT = 2;
  localparam int IOMAP_LSB = 16;
  localparam int TRAP_BIT = 0;
  localparam logic [15:0] IOMAP_TYPICAL = 16'h0068;
  localparam logic [1:0] PRIV_MOST = 2'h0;
  localparam logic [15:0] SEL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    OP_JMP = 2'h0,
    OP_CALL = 2'h1,
    OP_LOAD_SEL = 2'h2,
    OP_STORE_SEL = 2'h3
  } tsu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SAVE = 3'h1,
    ST_LOAD = 3'h3,
    ST_LINK = 3'h2,
    ST_DONE = 3'h6
  } tsu_state_t;
endpackage : tsu_pkg

/* rtl/tsu_ram_if.sv */
// Purpose: Port bundle between sequencer and state memory
// Assumes: One write and one registered read per cycle
// Notes: None
`timescale 1ns/10ps
interface tsu_ram_if;
  import tsu_pkg::*;
  logic we;
  logic [SLOT_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [SLOT_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tsu_ram_if

/* rtl/tsu_state_ram.sv */
// Purpose: Live task state image, one word per segment slot
// Assumes: Read data registered, one cycle latency
// Notes: No reset on storage; contents undefined until written
`timescale 1ns/10ps
module tsu_state_ram
  import tsu_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH
) (
  input wire logic i_clk,
  tsu_ram_if.mem port
);
  logic [DATA_W-1:0] mem_q [DEPTH];

  always_ff @(posedge i_clk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    port.rdata <= mem_q[port.raddr];
  end
endmodule : tsu_state_ram

/* rtl/tsu_priv_check.sv */
// Purpose: Privilege checks for gate transfers and selector loads
// Assumes: Inputs stable while a request is presented
// Notes: Purely combinational
`timescale 1ns/10ps
module tsu_priv_check
  import tsu_pkg::*;
(
  input wire logic i_prot_mode,
  input wire logic [1:0] i_cur_priv,
  input wire logic [1:0] i_req_priv,
  input wire logic [1:0] i_gate_priv,
  input wire logic i_is_gate,
  output logic o_gate_ok,
  output logic o_load_ok,
  output logic o_store_ok
);
  // Gate's own selector privilege field never enters here
  always_comb begin
    o_gate_ok = !i_is_gate
                || ((i_req_priv < i_gate_priv) && (i_cur_priv < i_gate_priv));
    o_load_ok = i_prot_mode && (i_cur_priv == PRIV_MOST);
    o_store_ok = i_prot_mode;
  end
endmodule : tsu_priv_check

/* tb/tsu_mem_model.sv */
// Purpose: Memory partner holding task state segments
// Assumes: Ack is a one-cycle pulse after a set number of wait cycles
// Notes: Read data is a pattern of the address; idle data keeps toggling
`timescale 1ns/10ps
module tsu_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [3:0] wait_reg;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    wait_reg = 4'h0;
  end
  always @(posedge i_clk) begin
    if (i_req && !o_ack && wait_reg == i_delay) begin
      o_ack <= 1'b1;
      o_rdata <= {i_addr[15:0], ~i_addr[15:0]};
      wait_reg <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      // Stale data must never look valid
      o_rdata <= ~o_rdata;
      wait_reg <= (i_req && !o_ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule : tsu_mem_model

/* tb/tsu_task_switch_sva.sv */
// Purpose: Port-level assertions for the task switch unit
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the top module at the foot of this file
`timescale 1ns/10ps
module tsu_task_switch_sva
  import tsu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_prot_mode,
  input wire logic [1:0] i_cur_priv,
  input wire logic i_req_valid,
  input wire tsu_op_t i_req_op,
  input wire logic [15:0] i_req_sel,
  input wire logic [3:0] i_desc_type,
  input wire logic [1:0] i_desc_priv,
  input wire logic i_mem_ack,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic o_mem_half,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_fault,
  input wire logic [15:0] o_store_sel
);
  logic take;
  logic sw_op;
  logic store_q;
  assign take = i_req_valid && !o_busy;
  assign sw_op = i_req_op == OP_JMP || i_req_op == OP_CALL;
  always_ff @(posedge i_clk) begin
    store_q <= i_nrst && take && i_req_op == OP_STORE_SEL;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_load_prot_only: assert property (
    take && i_req_op == OP_LOAD_SEL && !i_prot_mode |=> o_fault && !o_done)
    else $error("selector load outside protected mode not refused");
  a_load_priv_zero: assert property (
    take && i_req_op == OP_LOAD_SEL && i_cur_priv != PRIV_MOST |=> o_fault)
    else $error("selector load above privilege 0 not refused");
  a_load_global_tbl: assert property (
    take && i_req_op == OP_LOAD_SEL && i_req_sel[SEL_TI_BIT] |=> o_fault)
    else $error("selector load from local table not refused");
  a_gate_priv_chk: assert property (
    take && sw_op && i_desc_type == TYPE_TASK_GATE &&
    (i_req_sel[1:0] >= i_desc_priv || i_cur_priv >= i_desc_priv) |=> o_fault && !o_busy)
    else $error("gate privilege violation not refused");
  a_switch_starts: assert property (
    take && sw_op && (i_desc_type == TYPE_AVAIL32 || i_desc_type == TYPE_AVAIL16)
    |=> o_busy && !o_fault)
    else $error("switch to state segment did not start");
  a_mem_req_holds: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) &&
    $stable(o_mem_wdata) && $stable(o_mem_we) && $stable(o_mem_half))
    else $error("memory request changed before ack");
  a_idle_no_mem: assert property (
    !o_busy |-> !o_mem_req)
    else $error("memory request while idle");
  a_half_upper_zero: assert property (
    o_mem_req && o_mem_we && o_mem_half |-> o_mem_wdata[31:16] == 16'h0000)
    else $error("16-bit write with nonzero upper half");
  a_sel_only_store: assert property (
    !store_q |-> $stable(o_store_sel))
    else $error("returned selector changed without store");
  a_done_idle: assert property (
    o_done |-> !o_busy && !o_fault)
    else $error("done while busy or faulting");
endmodule : tsu_task_switch_sva

bind tsu_task_switch tsu_task_switch_sva u_sva (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_prot_mode(i_prot_mode), .i_cur_priv(i_cur_priv), .i_req_valid(i_req_valid),
  .i_req_op(i_req_op), .i_req_sel(i_req_sel), .i_desc_type(i_desc_type),
  .i_desc_priv(i_desc_priv), .i_mem_ack(i_mem_ack), .o_mem_req(o_mem_req),
  .o_mem_we(o_mem_we), .o_mem_half(o_mem_half), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .o_busy(o_busy), .o_done(o_done), .o_fault(o_fault),
  .o_store_sel(o_store_sel));

/* tb/tsu_task_switch_tb.sv */
// Purpose: Self-checking bench for the task switch unit
// Assumes: Inputs driven 2 ns after the rising edge
// Notes: Memory traffic is logged at each ack edge and compared afterwards
`timescale 1ns/10ps
module tsu_task_switch_tb;
  import tsu_pkg::*;
  logic i_clk, i_nrst, i_prot_mode, i_req_valid, i_core_we, i_mem_ack;
  logic [1:0] i_cur_priv, i_desc_priv, res;
  tsu_op_t i_req_op;
  logic [15:0] i_req_sel, i_gate_sel, o_store_sel, o_iomap_base;
  logic [3:0] i_desc_type, i_tgt_type, ack_dly;
  logic [31:0] i_desc_base, i_tgt_base, i_core_wdata, o_core_rdata, i_mem_rdata;
  logic [31:0] o_mem_addr, o_mem_wdata;
  logic [4:0] i_core_idx;
  logic o_mem_req, o_mem_we, o_mem_half, o_busy, o_done, o_fault, o_debug_trap;
  logic [33:0] log_q[$];
  logic [31:0] wd_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;

  tsu_task_switch u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_prot_mode(i_prot_mode),
    .i_cur_priv(i_cur_priv), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
    .i_req_sel(i_req_sel), .i_desc_type(i_desc_type), .i_desc_priv(i_desc_priv),
    .i_desc_base(i_desc_base), .i_desc_limit(32'h0000_00FF), .i_gate_sel(i_gate_sel),
    .i_tgt_type(i_tgt_type), .i_tgt_base(i_tgt_base), .i_tgt_limit(32'h0000_00FF),
    .i_core_we(i_core_we), .i_core_idx(i_core_idx), .i_core_wdata(i_core_wdata),
    .o_core_rdata(o_core_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_half(o_mem_half), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done),
    .o_fault(o_fault), .o_store_sel(o_store_sel), .o_iomap_base(o_iomap_base),
    .o_debug_trap(o_debug_trap));
  tsu_mem_model u_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .i_delay(ack_dly), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_mem_req === 1'b1 && i_mem_ack === 1'b1) begin
      log_q.push_back({o_mem_we, o_mem_half, o_mem_addr});
      wd_q.push_back(o_mem_wdata);
    end
    cyc++;
    // Full run needs well under 20000 cycles
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic issue(input tsu_op_t op, input logic [15:0] sel, input logic [3:0] ty,
                       input logic [1:0] dp, input logic [31:0] base);
    @(posedge i_clk);
    #2;
    log_q.delete();
    wd_q.delete();
    i_req_valid = 1'b1;
    i_req_op = op;
    i_req_sel = sel;
    i_desc_type = ty;
    i_desc_priv = dp;
    i_desc_base = base;
    @(posedge i_clk);
    #2;
    i_req_valid = 1'b0;
    for (int i = 0; i < 600 && o_done !== 1'b1 && o_fault !== 1'b1; i++) begin
      @(posedge i_clk);
      #2;
    end
    res = {o_fault, o_done};
  endtask : issue

  task automatic fchk(input string what);
    chk(what, 34'(2'h2), 34'(res));
    chk({what, " traffic"}, 34'h0, 34'(log_q.size()));
  endtask : fchk

  task automatic sel_is(input logic [15:0] exp);
    issue(OP_STORE_SEL, 16'h0000, 4'h0, 2'h0, 32'h0);
    chk("store done", 34'(2'h1), 34'(res));
    chk("stored selector", 34'(exp), 34'(o_store_sel));
  endtask : sel_is

  task automatic chk_seq(input logic [31:0] ob, input int os, input int on,
                         input logic [31:0] nb, input int ns, input int nn, input bit call);
    logic [33:0] e[$];
    e = {};
    for (int k = 1; k <= on; k++) e.push_back({1'b1, os == 1, ob + 32'(k << os)});
    for (int k = 0; k <= nn; k++) e.push_back({1'b0, ns == 1, nb + 32'(k << ns)});
    if (call) e.push_back({1'b1, ns == 1, nb});
    chk("transfer count", 34'(e.size()), 34'(log_q.size()));
    for (int k = 0; k < e.size() && k < log_q.size(); k++) chk("transfer", e[k], log_q[k]);
  endtask : chk_seq

  task automatic t_loads;
    chk("iomap reset", 34'(IOMAP_TYPICAL), 34'(o_iomap_base));
    sel_is(16'h0000);
    i_prot_mode = 1'b0;
    issue(OP_LOAD_SEL, 16'h0008, TYPE_AVAIL32, 2'h0, 32'h1000);
    fchk("load real mode");
    issue(OP_STORE_SEL, 16'h0000, 4'h0, 2'h0, 32'h0);
    fchk("store real mode");
    i_prot_mode = 1'b1;
    i_cur_priv = 2'h1;
    issue(OP_LOAD_SEL, 16'h0008, TYPE_AVAIL32, 2'h0, 32'h1000);
    fchk("load priv 1");
    i_cur_priv = 2'h0;
    issue(OP_LOAD_SEL, 16'h000C, TYPE_AVAIL32, 2'h0, 32'h1000);
    fchk("load local table");
    issue(OP_LOAD_SEL, 16'h0008, TYPE_TASK_GATE, 2'h0, 32'h1000);
    fchk("load gate type");
    sel_is(16'h0000);
    issue(OP_LOAD_SEL, 16'h0008, TYPE_AVAIL32, 2'h0, 32'h1000);
    chk("load ok", 34'(2'h1), 34'(res));
    sel_is(16'h0008);
  endtask : t_loads

  task automatic t_jump32;
    for (int k = 0; k <= 25; k++) begin
      @(posedge i_clk);
      #2;
      i_core_we = 1'b1;
      i_core_idx = 5'(k);
      i_core_wdata = {16'hFFFF, 11'h0, 5'(k)};
    end
    @(posedge i_clk);
    #2;
    i_core_we = 1'b0;
    ack_dly = 4'h0;
    issue(OP_JMP, 16'h0010, TYPE_AVAIL32, 2'h0, 32'h2000);
    chk("jump done", 34'(2'h1), 34'(res));
    chk_seq(32'h1000, 2, 25, 32'h2000, 2, 25, 1'b0);
    for (int k = 1; k <= 25 && k <= wd_q.size(); k++)
      chk("save data", 34'((k == 2 || k == 4 || k == 6 || (k >= 18 && k <= 24)) ?
        {16'h0, 11'h0, 5'(k)} : {16'hFFFF, 11'h0, 5'(k)}), 34'(wd_q[k-1]));
    chk("iomap", 34'h2064, 34'(o_iomap_base));
    chk("trap", 34'h1, 34'(o_debug_trap));
    i_core_idx = SLOT_IOMAP;
    repeat (2) @(posedge i_clk);
    #2;
    chk("image iomap", 34'(32'h2064DF9B), 34'(o_core_rdata));
    sel_is(16'h0010);
  endtask : t_jump32

  task automatic t_gate_call16;
    ack_dly = 4'h2;
    i_gate_sel = 16'h0023;
    i_tgt_type = TYPE_AVAIL16;
    i_tgt_base = 32'h3000;
    // Gate selector privilege 3 would fail if it were not ignored
    issue(OP_CALL, 16'h0019, TYPE_TASK_GATE, 2'h2, 32'h0);
    chk("gate call done", 34'(2'h1), 34'(res));
    chk_seq(32'h2000, 2, 25, 32'h3000, 1, 21, 1'b1);
    chk("back link", 34'(32'h0010), 34'(wd_q[wd_q.size()-1]));
    // Words loaded by the jump come back out unchanged, selectors trimmed
    chk("resaved word", 34'(32'h2004DFFB), 34'(wd_q[0]));
    chk("resaved selector", 34'(32'h0000DFF7), 34'(wd_q[1]));
    chk("iomap kept", 34'h2064, 34'(o_iomap_base));
    sel_is(16'h0023);
  endtask : t_gate_call16

  task automatic t_gate_faults;
    ack_dly = 4'h1;
    i_tgt_type = TYPE_AVAIL32;
    issue(OP_JMP, 16'h0002, TYPE_TASK_GATE, 2'h2, 32'h0);
    fchk("gate rpl equal");
    i_cur_priv = 2'h2;
    issue(OP_CALL, 16'h0000, TYPE_TASK_GATE, 2'h2, 32'h0);
    fchk("gate cpl equal");
    i_cur_priv = 2'h0;
    i_tgt_type = 4'h4;
    issue(OP_JMP, 16'h0001, TYPE_TASK_GATE, 2'h2, 32'h0);
    fchk("gate bad target");
    issue(OP_JMP, 16'h0018, 4'h2, 2'h0, 32'h4000);
    fchk("jump bad type");
  endtask : t_gate_faults

  task automatic results;
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  initial begin
    i_nrst = 1'b0;
    i_prot_mode = 1'b1;
    i_cur_priv = 2'h0;
    i_req_valid = 1'b0;
    i_req_op = OP_JMP;
    i_req_sel = 16'h0;
    i_desc_type = 4'h0;
    i_desc_priv = 2'h0;
    i_desc_base = 32'h0;
    i_gate_sel = 16'h0;
    i_tgt_type = 4'h0;
    i_tgt_base = 32'h0;
    i_core_we = 1'b0;
    i_core_idx = 5'h0;
    i_core_wdata = 32'h0;
    ack_dly = 4'h0;
    repeat (20) @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    t_loads();
    t_jump32();
    t_gate_call16();
    t_gate_faults();
    results();
  end
endmodule : tsu_task_switch_tb
